// File: logic/srs_pkg.sv
// Purpose: Shared constants and types of the system-interface request sequencer
// Assumes: One clock; all pins sampled synchronously
// Notes:   Command byte encodings and data identifier layout live here; the agent model and testbench also hard-code them
`default_nettype none

package srs_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 32;
  localparam int DATA_W     = 32;
  localparam int CMD_W      = 9;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // Command bus layout
  // ----------------------------------------------------------------
  localparam int CMD_TYPE_BIT = 8;
  localparam int ID_ERR_BIT   = 5;
  localparam int ID_LAST_BIT  = 7;
  localparam int KIND_LSB     = 5;

  localparam logic [2:0] KIND_READ  = 3'h0;
  localparam logic [2:0] KIND_WRITE = 3'h2;
  localparam logic [2:0] KIND_NULL  = 3'h3;

  localparam logic [7:0] CMD_READ  = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h40;
  localparam logic [7:0] ID_NEOD   = 8'h80;
  localparam logic [7:0] ID_ERROR  = 8'hA0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         WR_GAP_CYCLES = 4;
  localparam logic [2:0] WR_GAP_LOAD   = 3'(WR_GAP_CYCLES);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE      = 8'h01,
    ST_RD_ISSUE  = 8'h02,
    ST_WR_ISSUE  = 8'h04,
    ST_WR_DATA   = 8'h08,
    ST_RELEASE   = 8'h10,
    ST_SLAVE     = 8'h20,
    ST_EXT_WDATA = 8'h40,
    ST_EXT_RESP  = 8'h80
  } srs_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } srs_wreq_s;

  typedef struct packed {
    logic [DATA_W-1:0] busOut;
    logic [CMD_W-1:0]  cmdOut;
    logic              driveN;
    logic              validN;
    logic              releaseN;
  } srs_pin_s;

  typedef struct packed {
    srs_state_e        state;
    logic              readPending;
    logic [2:0]        gapCnt;
    logic [1:0]        rdHist;
    logic [1:0]        wrHist;
    logic              extHist;
    logic              preferExt;
    logic [ADDR_W-1:0] extAddr;
    srs_pin_s          pin;
    logic              respValid;
    logic [DATA_W-1:0] respData;
    logic              respLast;
    logic              busErr;
    logic              intWr;
    logic [ADDR_W-1:0] intAddr;
    logic [DATA_W-1:0] intData;
  } srs_ctl_s;

  localparam srs_pin_s PIN_RST = '{busOut: '0, cmdOut: '0, driveN: 1'b0,
                                   validN: 1'b1, releaseN: 1'b1};

  localparam srs_ctl_s CTL_RST = '{state: ST_IDLE, pin: PIN_RST, rdHist: 2'h3,
                                   wrHist: 2'h3, extHist: 1'b1, default: '0};

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic isAddrCycle(input logic [CMD_W-1:0] cmd);
    return !cmd[CMD_TYPE_BIT];
  endfunction : isAddrCycle

  function automatic logic [2:0] cmdKind(input logic [CMD_W-1:0] cmd);
    return cmd[KIND_LSB +: 3];
  endfunction : cmdKind

endpackage : srs_pkg

`default_nettype wire

// File: logic/srs_fifo.sv
// Purpose: Small write buffer FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes:   Read data comes straight from the storage flops
`default_nettype none

module srs_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             arstN,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wrPtr;
    logic [PW-1:0]               rdPtr;
    logic [PW:0]                 count;
  } srs_fifo_s;

  srs_fifo_s q;
  srs_fifo_s d;
  logic      push;
  logic      pop;

  assign inReady  = (q.count != (PW+1)'(DEPTH));
  assign outValid = (q.count != '0);
  assign outData  = q.mem[q.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wrPtr] = inData;
      d.wrPtr        = q.wrPtr + PW'(1);
    end
    if (pop) begin
      d.rdPtr = q.rdPtr + PW'(1);
    end
    case ({push, pop})
      2'b10:   d.count = q.count + (PW+1)'(1);
      2'b01:   d.count = q.count - (PW+1)'(1);
      default: d.count = q.count;
    endcase
  end

  always_ff @(posedge clock or negedge arstN) begin
    if (!arstN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : srs_fifo

`default_nettype wire

// File: logic/srs_sequencer.sv
// Purpose: Sequencing and arbitration of processor and external requests
// Assumes: Agent keeps its own pacing rules; pins synchronous to clock
// Notes:   Pin outputs are registered images of the next state
`default_nettype none

module srs_sequencer (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        arstN,
  // Mode
  input  wire logic                        legacyMode,
  // Core read request
  input  wire logic                        rdReqValid,
  input  wire logic [srs_pkg::ADDR_W-1:0]  rdReqAddr,
  output logic                             rdReqReady,
  // Write buffer fill side
  input  wire logic                        wbValid,
  input  wire srs_pkg::srs_wreq_s          wbReq,
  output logic                             wbReady,
  // Read response to core
  output logic                             rdRespValid,
  output logic [srs_pkg::DATA_W-1:0]       rdRespData,
  output logic                             rdRespLast,
  output logic                             busError,
  // Interrupt register write
  output logic                             intWrValid,
  output logic [srs_pkg::ADDR_W-1:0]       intWrAddr,
  output logic [srs_pkg::DATA_W-1:0]       intWrData,
  // Address/data and command pins
  input  wire logic [srs_pkg::DATA_W-1:0]  muxAddrDataBusIn,
  output logic [srs_pkg::DATA_W-1:0]       muxAddrDataBusOut,
  output logic                             muxAddrDataBusOeN,
  input  wire logic [srs_pkg::CMD_W-1:0]   cycleCommandBusIn,
  output logic [srs_pkg::CMD_W-1:0]        cycleCommandBusOut,
  output logic                             cycleCommandBusOeN,
  // Handshake pins
  input  wire logic                        readAcceptReadyN,
  input  wire logic                        writeAcceptReadyN,
  input  wire logic                        busRequestFromAgentN,
  output logic                             releaseN,
  output logic                             masterValidStrobeN,
  input  wire logic                        slaveValidStrobeN
);

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  srs_pkg::srs_ctl_s  q;
  srs_pkg::srs_ctl_s  d;
  srs_pkg::srs_wreq_s wbHead;
  logic               wbHeadValid;
  logic               wbPop;

  srs_fifo #(
    .WIDTH ($bits(srs_pkg::srs_wreq_s)),
    .DEPTH (srs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .arstN    (arstN),
    .inValid  (wbValid),
    .inData   (wbReq),
    .inReady  (wbReady),
    .outValid (wbHeadValid),
    .outData  (wbHead),
    .outReady (wbPop)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic agentCycle;
  logic agentAddr;
  logic agentData;
  logic extWant;
  logic rdIssueOk;
  logic wrIssueOk;

  assign agentCycle = !slaveValidStrobeN;
  assign agentAddr  = agentCycle && srs_pkg::isAddrCycle(cycleCommandBusIn);
  assign agentData  = agentCycle && !srs_pkg::isAddrCycle(cycleCommandBusIn);
  assign extWant    = !busRequestFromAgentN;
  assign rdIssueOk  = (q.state == srs_pkg::ST_RD_ISSUE) && !q.rdHist[1];
  assign wrIssueOk  = (q.state == srs_pkg::ST_WR_ISSUE) && !q.wrHist[1];
  assign rdReqReady = rdIssueOk;
  assign wbPop      = (q.state == srs_pkg::ST_WR_DATA);

  // ----------------------------------------------------------------
  // Pin image of a state
  // ----------------------------------------------------------------
  function automatic srs_pkg::srs_pin_s pinsFor(
    input srs_pkg::srs_state_e st,
    input logic [srs_pkg::ADDR_W-1:0] rdAddr,
    input srs_pkg::srs_wreq_s wr
  );
    srs_pkg::srs_pin_s p;
    p = srs_pkg::PIN_RST;
    case (st)
      srs_pkg::ST_RD_ISSUE: begin
        p.busOut = rdAddr;
        p.cmdOut = {1'b0, srs_pkg::CMD_READ};
        p.validN = 1'b0;
      end
      srs_pkg::ST_WR_ISSUE: begin
        p.busOut = wr.addr;
        p.cmdOut = {1'b0, srs_pkg::CMD_WRITE};
        p.validN = 1'b0;
      end
      srs_pkg::ST_WR_DATA: begin
        p.busOut = wr.data;
        p.cmdOut = {1'b1, srs_pkg::ID_NEOD};
        p.validN = 1'b0;
      end
      srs_pkg::ST_RELEASE: begin
        p.releaseN = 1'b0;
      end
      srs_pkg::ST_SLAVE, srs_pkg::ST_EXT_WDATA: begin
        p.driveN = 1'b1;
      end
      srs_pkg::ST_EXT_RESP: begin
        p.cmdOut = {1'b1, srs_pkg::ID_ERROR};
        p.validN = 1'b0;
      end
      default: begin
        p = srs_pkg::PIN_RST;
      end
    endcase
    return p;
  endfunction : pinsFor

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d           = q;
    d.rdHist    = {q.rdHist[0], readAcceptReadyN};
    d.wrHist    = {q.wrHist[0], writeAcceptReadyN};
    d.extHist   = busRequestFromAgentN;
    d.respValid = 1'b0;
    d.respLast  = 1'b0;
    d.busErr    = 1'b0;
    d.intWr     = 1'b0;
    if (q.gapCnt != 3'h0) begin
      d.gapCnt = q.gapCnt - 3'h1;
    end
    case (q.state)
      srs_pkg::ST_IDLE: begin
        // Gap blocks every request, own and external alike
        if (q.gapCnt == 3'h0 && !q.readPending) begin
          if (extWant && (q.preferExt || !(wbHeadValid || rdReqValid))) begin
            d.state     = srs_pkg::ST_RELEASE;
            d.preferExt = 1'b0;
          end else if (wbHeadValid) begin
            // Buffered writes drain before any read goes out
            d.state     = srs_pkg::ST_WR_ISSUE;
            d.preferExt = 1'b1;
          end else if (rdReqValid) begin
            d.state     = srs_pkg::ST_RD_ISSUE;
            d.preferExt = 1'b1;
          end
        end
      end
      srs_pkg::ST_RD_ISSUE: begin
        if (rdIssueOk) begin
          d.readPending = 1'b1;
          d.state       = srs_pkg::ST_RELEASE;
        end else if (extWant && !q.extHist && q.rdHist[0]) begin
          d.state = srs_pkg::ST_RELEASE;
        end
      end
      srs_pkg::ST_WR_ISSUE: begin
        if (wrIssueOk) begin
          d.state  = srs_pkg::ST_WR_DATA;
          d.gapCnt = legacyMode ? srs_pkg::WR_GAP_LOAD : 3'h0;
        end else if (extWant && !q.extHist && q.wrHist[0]) begin
          d.state = srs_pkg::ST_RELEASE;
        end
      end
      srs_pkg::ST_WR_DATA: begin
        d.state = srs_pkg::ST_IDLE;
      end
      srs_pkg::ST_RELEASE: begin
        d.state = srs_pkg::ST_SLAVE;
      end
      srs_pkg::ST_SLAVE: begin
        // Agent may start here unasked once a read is pending
        if (agentAddr) begin
          case (srs_pkg::cmdKind(cycleCommandBusIn))
            srs_pkg::KIND_READ: begin
              d.state = srs_pkg::ST_EXT_RESP;
            end
            srs_pkg::KIND_WRITE: begin
              d.extAddr = muxAddrDataBusIn;
              d.state   = srs_pkg::ST_EXT_WDATA;
            end
            default: begin
              d.state = q.readPending ? srs_pkg::ST_RELEASE : srs_pkg::ST_IDLE;
            end
          endcase
        end else if (agentData && q.readPending) begin
          d.respValid = 1'b1;
          d.respData  = muxAddrDataBusIn;
          d.respLast  = cycleCommandBusIn[srs_pkg::ID_LAST_BIT];
          d.busErr    = cycleCommandBusIn[srs_pkg::ID_ERR_BIT];
          if (cycleCommandBusIn[srs_pkg::ID_LAST_BIT]) begin
            d.readPending = 1'b0;
            d.state       = srs_pkg::ST_IDLE;
          end
        end
      end
      srs_pkg::ST_EXT_WDATA: begin
        if (agentData) begin
          d.intWr   = 1'b1;
          d.intAddr = q.extAddr;
          d.intData = muxAddrDataBusIn;
          d.state   = q.readPending ? srs_pkg::ST_RELEASE : srs_pkg::ST_IDLE;
        end
      end
      srs_pkg::ST_EXT_RESP: begin
        d.state = q.readPending ? srs_pkg::ST_RELEASE : srs_pkg::ST_IDLE;
      end
      default: begin
        d.state = srs_pkg::ST_IDLE;
      end
    endcase
    d.pin = pinsFor(d.state, rdReqAddr, wbHead);
  end

  always_ff @(posedge clock or negedge arstN) begin
    if (!arstN) begin
      q <= srs_pkg::CTL_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign muxAddrDataBusOut  = q.pin.busOut;
  assign muxAddrDataBusOeN  = q.pin.driveN;
  assign cycleCommandBusOut = q.pin.cmdOut;
  assign cycleCommandBusOeN = q.pin.driveN;
  assign masterValidStrobeN = q.pin.validN;
  assign releaseN           = q.pin.releaseN;
  assign rdRespValid        = q.respValid;
  assign rdRespData         = q.respData;
  assign rdRespLast         = q.respLast;
  assign busError           = q.busErr;
  assign intWrValid         = q.intWr;
  assign intWrAddr          = q.intAddr;
  assign intWrData          = q.intData;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arstN);

  logic ownAddrOut;
  assign ownAddrOut = !q.pin.validN && !q.pin.cmdOut[srs_pkg::CMD_TYPE_BIT];

  sequence legacyWrIssue;
    wrIssueOk && legacyMode;
  endsequence

  sequence slaveRespErr;
    q.state == srs_pkg::ST_SLAVE && q.readPending && agentData
      && cycleCommandBusIn[srs_pkg::ID_ERR_BIT];
  endsequence

  release_pulse_a: assert property ($fell(releaseN) |=> releaseN)
    else $error("release strobe longer than one cycle");

  release_after_issue_a: assert property (rdIssueOk |=> !releaseN ##1 muxAddrDataBusOeN)
    else $error("bus not released after read issue");

  read_single_a: assert property (rdReqReady |-> !q.readPending)
    else $error("second read issued while one pending");

  read_gated_a: assert property (rdReqReady |-> !$past(readAcceptReadyN, 2))
    else $error("read issued without read-ready two cycles earlier");

  write_gated_a: assert property (wrIssueOk |-> !$past(writeAcceptReadyN, 2))
    else $error("write issued without write-ready two cycles earlier");

  write_no_read_a: assert property (q.state == srs_pkg::ST_WR_ISSUE |-> !q.readPending)
    else $error("write issued while read pending");

  legacy_gap_a: assert property (legacyWrIssue |=> !ownAddrOut [*5])
    else $error("request issued within four cycles of a write");

  dummy_cycles_a: assert property (legacyWrIssue |=> ##1 masterValidStrobeN [*2])
    else $error("missing dummy cycles after write");

  ext_read_err_a: assert property (
    q.state == srs_pkg::ST_SLAVE && agentAddr
      && srs_pkg::cmdKind(cycleCommandBusIn) == srs_pkg::KIND_READ
    |=> !masterValidStrobeN && cycleCommandBusOut[srs_pkg::CMD_TYPE_BIT]
        && cycleCommandBusOut[srs_pkg::ID_ERR_BIT])
    else $error("external read not answered with error identifier");

  bus_error_a: assert property (slaveRespErr |=> busError && rdRespValid)
    else $error("error identifier did not raise bus error");

  read_complete_a: assert property (
    q.state == srs_pkg::ST_SLAVE && q.readPending && agentData
      && cycleCommandBusIn[srs_pkg::ID_LAST_BIT]
    |=> !q.readPending && rdRespLast)
    else $error("read not completed on last word");

  int_write_a: assert property (
    q.state == srs_pkg::ST_EXT_WDATA && agentData |=> intWrValid && intWrAddr == $past(q.extAddr))
    else $error("external write did not reach interrupt port");

endmodule : srs_sequencer

`default_nettype wire

// File: testbench/srs_agent_model.sv
// Purpose: Behavioural external agent facing the sequencer pins
// Assumes: Bench picks pacing, request kind and response words
// Notes:   Lines it has released toggle, so stale values never look valid
`default_nettype none
module srs_agent_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arstN,
  // Bench control
  input  wire logic        holdRdy,
  input  wire logic        extGo,
  input  wire logic [2:0]  extKind,
  input  wire logic [2:0]  respWords,
  input  wire logic        respErr,
  input  wire logic [31:0] respBase,
  output logic             extDone,
  // Device pins
  input  wire logic [8:0]  cmdOut,
  input  wire logic        busOeN,
  input  wire logic        releaseN,
  input  wire logic        validN,
  output logic             readyRdN,
  output logic             readyWrN,
  output logic             reqN,
  output logic             validInN,
  output logic [31:0]      busToDev,
  output logic [8:0]       cmdToDev
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] rdHist;
  logic       pend;
  logic       grant;
  logic       step;
  logic [2:0] word;
  assign readyRdN = holdRdy;
  assign readyWrN = holdRdy;
  // ----
  // Responses and external requests
  // ----
  always_ff @(posedge clock or negedge arstN) begin
    if (!arstN) begin
      {rdHist, pend, grant, step, word} <= 8'hC0;
      {reqN, validInN, extDone} <= 3'h6;
      busToDev <= '1;
      cmdToDev <= '1;
    end else begin
      rdHist   <= {rdHist[0], readyRdN};
      validInN <= 1'b1;
      extDone  <= 1'b0;
      busToDev <= ~busToDev;
      cmdToDev <= ~cmdToDev;
      if (!busOeN && !validN && cmdOut == 9'h000 && !rdHist[1])
        pend <= 1'b1;
      // No request line for responses: they never arbitrate
      if (pend && busOeN && !grant) begin
        validInN <= 1'b0;
        busToDev <= respBase + 32'(word);
        cmdToDev <= {1'b1, word == respWords - 3'h1, 1'b0, respErr, 5'h0};
        word     <= word + 3'h1;
        if (word == respWords - 3'h1) begin
          pend <= 1'b0;
          word <= 3'h0;
        end
      end
      if (extGo && reqN && !grant && !extDone)
        reqN <= 1'b0;
      if (!reqN && !releaseN) begin
        grant <= 1'b1;
        reqN  <= 1'b1;
      end
      if (grant && busOeN) begin
        validInN <= 1'b0;
        busToDev <= step ? ~respBase : respBase;
        cmdToDev <= step ? 9'h180 : {1'b0, extKind, 5'h0};
        step     <= 1'b1;
        if (step || extKind != srs_pkg::KIND_WRITE) begin
          grant   <= 1'b0;
          step    <= 1'b0;
          extDone <= 1'b1;
        end
      end
    end
  end
endmodule : srs_agent_model
`default_nettype wire

// File: testbench/testbench.sv
// Purpose: Self-checking bench of the request sequencer
// Assumes: Agent model on the far side, inputs driven on falling edges
// Notes:   Expected events queue up in order; the monitor pops them
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, arstN = 0, legacyMode = 0, rdReqValid = 0, wbValid = 0, holdRdy = 0;
  logic extGo = 0, respErr = 0, rdReqReady, wbReady, rdRespValid, rdRespLast, busError;
  logic intWrValid, busOeN, cmdOeN, releaseN, validN, readyRdN, readyWrN, reqN;
  logic validInN, extDone;
  logic [2:0] extKind = 0, respWords = 1;
  logic [31:0] rdReqAddr = 0, respBase = 0, rdRespData, intWrAddr, intWrData, busOut, busToDev;
  logic [8:0] cmdOut, cmdToDev;
  logic [15:0] seed = 16'h0006;
  srs_pkg::srs_wreq_s wbReq = '0;
  wire logic [31:0] busIn = busOeN ? busToDev : busOut;
  wire logic [8:0] cmdIn = cmdOeN ? cmdToDev : cmdOut;
  logic [71:0] expQ[$];
  int errTotal = 0, checks = 0;
  always #2 clock = ~clock;
  srs_sequencer dut_u (.clock, .arstN, .legacyMode, .rdReqValid, .rdReqAddr, .rdReqReady,
    .wbValid, .wbReq, .wbReady, .rdRespValid, .rdRespData, .rdRespLast, .busError,
    .intWrValid, .intWrAddr, .intWrData, .muxAddrDataBusIn(busIn),
    .muxAddrDataBusOut(busOut), .muxAddrDataBusOeN(busOeN), .cycleCommandBusIn(cmdIn),
    .cycleCommandBusOut(cmdOut), .cycleCommandBusOeN(cmdOeN),
    .readAcceptReadyN(readyRdN), .writeAcceptReadyN(readyWrN),
    .busRequestFromAgentN(reqN), .releaseN, .masterValidStrobeN(validN),
    .slaveValidStrobeN(validInN));
  srs_agent_model agent_u (.clock, .arstN, .holdRdy, .extGo, .extKind, .respWords, .respErr,
    .respBase, .extDone, .cmdOut, .busOeN, .releaseN, .validN, .readyRdN, .readyWrN, .reqN,
    .validInN, .busToDev, .cmdToDev);
  // ----
  // Shared tasks
  // ----
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finishTest;
    $display("comparisons %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finishTest
  task automatic drain(input string name);
    int k = 0;
    while (expQ.size() != 0 && k++ < 600) @(negedge clock);
    repeat (8) @(negedge clock);
    check("leftover", 72'(expQ.size()), 72'h0);
    $display("test %s done", name);
  endtask : drain
  task automatic do_read(input logic [2:0] n, input logic err);
    int k = 0;
    @(negedge clock);
    seed = lfsr(seed);
    {respWords, respErr, respBase} = {n, err, seed, 16'h0};
    for (int i = 0; i < n; i++) expQ.push_back({6'h10, err, i == n - 1, 32'h0, respBase + i});
    rdReqAddr = {16'h0, seed};
    rdReqValid = 1;
    while (rdReqReady !== 1'b1 && k++ < 300) @(negedge clock);
    @(negedge clock);
    rdReqValid = 0;
    drain("read");
  endtask : do_read
  task automatic push_wr(input logic gap);
    int k = 0;
    @(negedge clock);
    seed = lfsr(seed);
    if (gap) expQ.push_back({8'h50, 64'h1});
    expQ.push_back({8'h30, 48'h0, seed});
    wbReq = '{addr: {16'h0, seed}, data: {16'h0, seed}};
    wbValid = 1;
    while (wbReady !== 1'b1 && k++ < 300) @(negedge clock);
    @(negedge clock);
    wbValid = 0;
  endtask : push_wr
  task automatic do_ext(input logic [2:0] kind);
    int k = 0;
    @(negedge clock);
    seed = lfsr(seed);
    respBase = {seed, seed};
    extKind = kind;
    if (kind == srs_pkg::KIND_READ) expQ.push_back({8'h40, 64'h0});
    if (kind == srs_pkg::KIND_WRITE) expQ.push_back({8'h20, respBase, ~respBase});
    extGo = 1;
    while (extDone !== 1'b1 && k++ < 300) @(negedge clock);
    check("extDone", 72'(extDone), 72'h1);
    extGo = 0;
  endtask : do_ext
  // ----
  // Output monitor
  // ----
  logic pendRd = 0, afterWr = 0, wasAddr = 0;
  logic [2:0] sinceWr = 0;
  always @(posedge clock) if (arstN) begin
    logic [71:0] ev;
    ev = '0;
    if (rdRespValid) ev = {6'h10, busError, rdRespLast, 32'h0, rdRespData};
    if (intWrValid) ev = {8'h20, intWrAddr, intWrData};
    if (!validN && !busOeN && cmdOut == 9'h180) ev = {8'h30, 32'h0, busOut};
    if (!validN && cmdOut == 9'h1A0) ev = {8'h40, 64'h0};
    if (!validN && !busOeN && !cmdOut[8] && !wasAddr) begin
      check("oneAtATime", 72'(pendRd), 72'h0);
      if (cmdOut == 9'h000) check("rdAddr", 72'(busOut), 72'(rdReqAddr));
      if (legacyMode && afterWr) ev = {8'h50, 63'h0, sinceWr >= 3'h3};
      afterWr = 0;
    end
    if (ev != 0 && expQ.size() == 0) check("unexpected", ev, 72'h0);
    else if (ev != 0) check("event", ev, expQ.pop_front());
    wasAddr = !validN && !busOeN && !cmdOut[8];
    sinceWr = sinceWr == 3'h7 ? sinceWr : sinceWr + 3'h1;
    if (!validN && cmdOut == 9'h180) {afterWr, sinceWr} = 4'h8;
    if (rdReqReady) pendRd = 1;
    if (rdRespValid && rdRespLast) pendRd = 0;
  end
  initial begin
    repeat (20000) @(posedge clock);
    errTotal++;
    finishTest;
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (16) @(negedge clock);
    arstN = 1;
    for (int n = 1; n <= 4; n++) do_read(3'(n), n == 4);
    {holdRdy, legacyMode} = 2'h3;
    for (int i = 0; i < 4; i++) push_wr(i != 0);
    check("wbFull", 72'(wbReady), 72'h0);
    holdRdy = 0;
    drain("legacyWrites");
    legacyMode = 0;
    push_wr(0);
    push_wr(0);
    drain("writes");
    do_ext(srs_pkg::KIND_READ);
    do_ext(srs_pkg::KIND_WRITE);
    do_ext(srs_pkg::KIND_NULL);
    drain("external");
    holdRdy = 1;
    push_wr(0);
    do_ext(srs_pkg::KIND_NULL);
    holdRdy = 0;
    drain("extDuringWrite");
    finishTest;
  end
endmodule : testbench
`default_nettype wire
